// file: verilog/sarcv_cfg.svh
`ifndef SARCV_CFG_SVH
`define SARCV_CFG_SVH
`define SARCV_CLK_MHZ 250
`define SARCV_POR_US 20
`define SARCV_POR_CYC (`SARCV_POR_US * `SARCV_CLK_MHZ)
`define SARCV_TCONV_NS 1500
`define SARCV_TCONV_CYC ((`SARCV_TCONV_NS * `SARCV_CLK_MHZ) / 1000)
`define SARCV_TACQ_NS 527
`define SARCV_TACQ_CYC ((`SARCV_TACQ_NS * `SARCV_CLK_MHZ + 999) / 1000)
`define SARCV_TQUIET_NS 40
`define SARCV_TQUIET_CYC ((`SARCV_TQUIET_NS * `SARCV_CLK_MHZ) / 1000)
`define SARCV_RES_BITS 16
`define SARCV_SCK_DIV 4
`endif

// file: verilog/sarcv_pkg.sv
package sarcv_pkg;
	typedef enum logic [1:0] {DEV_POR, DEV_IDLE, DEV_CONV} sarcv_dev_st_t;
	typedef enum logic [2:0] {HST_POR, HST_IDLE, HST_TRIG, HST_WAIT, HST_SHIFT} sarcv_hst_st_t;
endpackage : sarcv_pkg

// file: verilog/sarcv_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sarcv_link_if;
	logic conversion_trigger;
	logic busy;
	logic sck;
	logic read_enable_or_chain_input;
	logic sdo_o;
	logic sdo_oe_n;
	logic chain_mode;
	modport dev (input conversion_trigger, input sck, input read_enable_or_chain_input,
		input chain_mode, output busy, output sdo_o, output sdo_oe_n);
	modport hst (output conversion_trigger, output sck, output read_enable_or_chain_input,
		output chain_mode, input busy, input sdo_o, input sdo_oe_n);
endinterface : sarcv_link_if
`default_nettype wire

// file: verilog/sarcv_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sarcv_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sarcv_fifo_st_t;
	sarcv_fifo_st_t s_r, s_nxt;
	logic push, pop;
	assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : sarcv_fifo
`default_nettype wire

// file: verilog/sarcv_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "sarcv_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - reset on power-up or supply below 1V
// - host waits 20us after reset before converting
// - trigger rising edge powers up, starts conversion
// - trigger edges ignored while converting
// - busy high for whole conversion
// - extra trigger edges only early or after
// - after conversion, power down and acquire
// - acquisition starts 132 cycles (528ns, 527ns rounded up) after conversion start
// - conversion finishes within 1.5us, own clock
// - last result stays readable while powered down
// - host idles output and clock when down
// - shift only when enabled and sck toggles; device shifts on every sck rise while idle, read enable not checked
// - host shift clock at least 40MHz
// - sdo changes on sck rise, msb first
// - normal mode: read enable high tristates sdo
// - msb on sdo when busy falls
// - one read enable low, msb immediately
// - chain mode: sdo always on, serial input
// - chain captures input on each sck rise
// - result is straight unsigned binary
module sarcv_dev #(
	parameter int POR_CYC = `SARCV_POR_CYC,
	parameter int RES_BITS = `SARCV_RES_BITS
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic supply_ok,
	input wire logic [RES_BITS-1:0] sample_code,
	output logic powered_up,
	output logic acquiring,
	output logic ready,
	sarcv_link_if.dev link
);
	localparam int CONV_CYC = `SARCV_TCONV_CYC;
	localparam int ACQ_CYC = `SARCV_TACQ_CYC;
	typedef struct packed {
		sarcv_pkg::sarcv_dev_st_t st;
		logic [13:0] cnt;
		logic [RES_BITS-1:0] shreg;
		logic [2:0] cnv_s;
		logic [2:0] sck_s;
		logic [1:0] rd_s;
		logic [1:0] ch_s;
		logic [1:0] sup_s;
		logic busy;
		logic acq;
		logic pwr;
		logic rdy;
	} sarcv_dev_st_t;
	sarcv_dev_st_t s_r, s_nxt;
	logic cnv_rise, sck_rise, chain, rd_n;
	////////////////////////////////////////////////////////////////////////////
	assign cnv_rise = s_r.cnv_s[1] && !s_r.cnv_s[2];
	assign sck_rise = s_r.sck_s[1] && !s_r.sck_s[2];
	assign chain = s_r.ch_s[1];
	assign rd_n = s_r.rd_s[1];
	assign link.busy = s_r.busy;
	assign link.sdo_o = s_r.shreg[RES_BITS-1];
	// chain: always driving; normal: read enable low drives
	assign link.sdo_oe_n = chain ? 1'b0 : rd_n;
	assign powered_up = s_r.pwr;
	assign acquiring = s_r.acq;
	assign ready = s_r.rdy;
	always_comb begin
		s_nxt = s_r;
		s_nxt.cnv_s = {s_r.cnv_s[1:0], link.conversion_trigger};
		s_nxt.sck_s = {s_r.sck_s[1:0], link.sck};
		s_nxt.rd_s = {s_r.rd_s[0], link.read_enable_or_chain_input};
		s_nxt.ch_s = {s_r.ch_s[0], link.chain_mode};
		// supply monitor is a pin: two flops before use
		s_nxt.sup_s = {s_r.sup_s[0], supply_ok};
		case (s_r.st)
			sarcv_pkg::DEV_POR: begin
				// reinit period; conversions before its end are invalid
				s_nxt.cnt = s_r.cnt + 14'h0001;
				if (s_r.cnt >= 14'(POR_CYC - 1)) begin
					s_nxt.st = sarcv_pkg::DEV_IDLE;
					s_nxt.rdy = 1'b1;
					s_nxt.acq = 1'b1;
				end
			end
			sarcv_pkg::DEV_IDLE: begin
				if (cnv_rise) begin
					s_nxt.st = sarcv_pkg::DEV_CONV;
					s_nxt.cnt = '0;
					s_nxt.busy = 1'b1;
					s_nxt.pwr = 1'b1;
					s_nxt.acq = 1'b0;
				end else if (sck_rise) begin
					// shifting only in power-down, old result retained
					s_nxt.shreg = {s_r.shreg[RES_BITS-2:0],
						chain ? s_r.rd_s[1] : 1'b0};
				end
			end
			sarcv_pkg::DEV_CONV: begin
				// trigger edges ignored until done
				s_nxt.cnt = s_r.cnt + 14'h0001;
				if (s_r.cnt == 14'(ACQ_CYC - 1)) begin
					s_nxt.acq = 1'b1;
				end
				if (s_r.cnt == 14'(CONV_CYC - 1)) begin
					s_nxt.st = sarcv_pkg::DEV_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.pwr = 1'b0;
					s_nxt.acq = 1'b1;
					// straight binary, msb on sdo as busy falls
					s_nxt.shreg = sample_code;
				end
			end
			default: begin
				s_nxt.st = sarcv_pkg::DEV_POR;
			end
		endcase
		if (!s_r.sup_s[1]) begin
			s_nxt.st = sarcv_pkg::DEV_POR;
			s_nxt.cnt = '0;
			s_nxt.busy = 1'b0;
			s_nxt.pwr = 1'b0;
			s_nxt.acq = 1'b0;
			s_nxt.rdy = 1'b0;
			s_nxt.shreg = '0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : sarcv_dev
`default_nettype wire

// file: verilog/sarcv_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "sarcv_cfg.svh"
module sarcv_host #(
	parameter int POR_CYC = `SARCV_POR_CYC,
	parameter int RES_BITS = `SARCV_RES_BITS,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic chain_sel,
	input wire logic [4:0] words,
	output logic start_ready,
	output logic res_valid,
	input wire logic res_ready,
	output logic [RES_BITS-1:0] res_data,
	sarcv_link_if.hst link
);
	typedef struct packed {
		sarcv_pkg::sarcv_hst_st_t st;
		logic [13:0] cnt;
		logic [1:0] div;
		logic [4:0] bits;
		logic [4:0] wleft;
		logic [4:0] wtot;
		logic [RES_BITS-1:0] sh;
		logic [1:0] busy_s;
		logic [1:0] sdo_s;
		logic trig;
		logic sck;
		logic rd;
		logic push;
	} sarcv_host_st_t;
	sarcv_host_st_t s_r, s_nxt;
	logic fifo_ready;
	assign link.conversion_trigger = s_r.trig;
	assign link.sck = s_r.sck;
	assign link.read_enable_or_chain_input = s_r.rd;
	assign link.chain_mode = chain_sel;
	assign start_ready = (s_r.st == sarcv_pkg::HST_IDLE);
	sarcv_fifo #(.WIDTH(RES_BITS), .DEPTH(DEPTH)) i_sarcv_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(s_r.push),
		.in_ready(fifo_ready),
		.in_data(s_r.sh),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(res_data)
	);
	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.busy_s = {s_r.busy_s[0], link.busy};
		// a released line reads as the inverse, so an early sample shows up
		s_nxt.sdo_s = {s_r.sdo_s[0], link.sdo_o ^ link.sdo_oe_n};
		s_nxt.push = 1'b0;
		case (s_r.st)
			sarcv_pkg::HST_POR: begin
				s_nxt.cnt = s_r.cnt + 14'h0001;
				if (s_r.cnt >= 14'(POR_CYC - 1)) begin
					s_nxt.st = sarcv_pkg::HST_IDLE;
				end
			end
			sarcv_pkg::HST_IDLE: begin
				// reading idle: read enable high, sck low
				s_nxt.rd = 1'b1;
				if (start && fifo_ready) begin
					s_nxt.st = sarcv_pkg::HST_TRIG;
					s_nxt.trig = 1'b1;
					s_nxt.cnt = '0;
					s_nxt.wtot = (words == '0) ? 5'h01 : words;
				end
			end
			sarcv_pkg::HST_TRIG: begin
				// no more trigger edges until busy drops
				s_nxt.cnt = s_r.cnt + 14'h0001;
				if (s_r.busy_s[1]) begin
					s_nxt.st = sarcv_pkg::HST_WAIT;
				end
			end
			sarcv_pkg::HST_WAIT: begin
				if (!s_r.busy_s[1]) begin
					s_nxt.trig = 1'b0;
					// chain: ones stand in for an upstream device's bits
					s_nxt.rd = chain_sel ? 1'b1 : 1'b0;
					s_nxt.st = sarcv_pkg::HST_SHIFT;
					s_nxt.bits = '0;
					// first rise comes late so the output enable has settled
					s_nxt.div = 2'h3;
					s_nxt.wleft = s_r.wtot;
				end
			end
			sarcv_pkg::HST_SHIFT: begin
				// sck = clk/4 = 62.5MHz, above 40MHz minimum
				s_nxt.div = s_r.div + 2'h1;
				if (s_r.div == 2'h1 && !s_r.sck) begin
					s_nxt.sck = 1'b1;
					s_nxt.bits = s_r.bits + 5'h01;
				end else if (s_r.div == 2'h3 && s_r.sck) begin
					// sample at the fall: the round trip is too long for the next rise
					s_nxt.sh = {s_r.sh[RES_BITS-2:0], s_r.sdo_s[1]};
					s_nxt.sck = 1'b0;
					if (s_r.bits == 5'(RES_BITS)) begin
						s_nxt.push = 1'b1;
						s_nxt.bits = '0;
						s_nxt.wleft = s_r.wleft - 5'h01;
						if (s_r.wleft == 5'h01) begin
							s_nxt.st = sarcv_pkg::HST_IDLE;
							s_nxt.rd = 1'b1;
						end
					end
				end
			end
			default: begin
				s_nxt.st = sarcv_pkg::HST_POR;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.rd <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : sarcv_host
`default_nettype wire

// file: dv/sarcv_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sarcv_properties #(
	parameter int POR_CYC = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic conversion_trigger,
	input wire logic busy,
	input wire logic sck,
	input wire logic read_enable_or_chain_input,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	input wire logic chain_mode
);
	localparam int TCONV = 375;
	logic [9:0] bcnt_r;
	logic [15:0] pcnt_r;
	// counters instead of long repetitions, which the tools unroll
	always_ff @(posedge clk) begin
		bcnt_r <= srst ? 10'h000 : (busy ? bcnt_r + 10'h001 : 10'h000);
		pcnt_r <= srst ? 16'h0000 : ((pcnt_r < 16'(POR_CYC)) ? pcnt_r + 16'h0001 : pcnt_r);
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_busy_len; $fell(busy) |-> bcnt_r == 10'(TCONV); endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_no_restart; bcnt_r <= 10'(TCONV); endproperty
	a_no_restart: assert property (p_no_restart) else $error("busy too long");
	property p_trig; $rose(conversion_trigger) && !busy |-> ##[2:5] busy; endproperty
	a_trig: assert property (p_trig) else $error("no busy after trigger");
	property p_por; $rose(conversion_trigger) |-> pcnt_r >= 16'(POR_CYC - 1); endproperty
	a_por: assert property (p_por) else $error("trigger too early");
	property p_hiz; (!chain_mode && read_enable_or_chain_input) [*4] |-> sdo_oe_n; endproperty
	a_hiz: assert property (p_hiz) else $error("sdo driven while deselected");
	property p_drv; (!chain_mode && !read_enable_or_chain_input) [*4] |-> !sdo_oe_n; endproperty
	a_drv: assert property (p_drv) else $error("sdo not driven");
	property p_chain; chain_mode [*4] |-> !sdo_oe_n; endproperty
	a_chain: assert property (p_chain) else $error("chain sdo off");
	// shift only follows a clock rise; the load at end of conversion is the exception
	property p_shift; (!sck) [*6] |-> $stable(sdo_o) || $fell(busy); endproperty
	a_shift: assert property (p_shift) else $error("sdo moved without sck");
	property p_sck; $rose(sck) |-> sck [*2] ##1 !sck; endproperty
	a_sck: assert property (p_sck) else $error("sck too slow");
	property p_quiet; busy && $past(busy) |-> $stable(conversion_trigger); endproperty
	a_quiet: assert property (p_quiet) else $error("trigger moved in conversion");
endmodule : sarcv_properties
`default_nettype wire

// file: dv/sarcv_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sarcv_bench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic supply_ok = 1'b1;
	logic [15:0] sample_code = 16'h0000;
	logic start = 1'b0;
	logic chain_sel = 1'b0;
	logic [4:0] words = 5'h01;
	logic res_ready = 1'b0;
	logic ready, acquiring, powered_up, start_ready, res_valid;
	logic [15:0] res_data;
	int n_errors = 0;
	int checked = 0;
	sarcv_link_if lk();
	always #2 clk = ~clk;
	sarcv_dev #(.POR_CYC(20)) i_sarcv_dev (.clk(clk), .srst(srst), .supply_ok(supply_ok),
		.sample_code(sample_code), .powered_up(powered_up), .acquiring(acquiring),
		.ready(ready), .link(lk.dev));
	sarcv_host #(.POR_CYC(20)) i_sarcv_host (.clk(clk), .srst(srst), .start(start),
		.chain_sel(chain_sel), .words(words), .start_ready(start_ready), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data), .link(lk.hst));
	sarcv_properties #(.POR_CYC(20)) i_sarcv_properties (.clk(clk), .srst(srst),
		.conversion_trigger(lk.conversion_trigger), .busy(lk.busy), .sck(lk.sck),
		.read_enable_or_chain_input(lk.read_enable_or_chain_input), .sdo_o(lk.sdo_o),
		.sdo_oe_n(lk.sdo_oe_n), .chain_mode(lk.chain_mode));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task close_out;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	// code must stand until the end of conversion, where it is sampled
	task conv(input logic [15:0] code, input logic taken);
		int n;
		sample_code = code;
		start = 1'b1;
		for (n = 0; n < 100 && !lk.busy; n++) @(negedge clk);
		start = 1'b0;
		chk("busy", 16'(taken), 16'(lk.busy));
		for (n = 0; n < 700 && lk.busy; n++) @(negedge clk);
		if (taken) chk("msb", 16'(code[15]), 16'(lk.sdo_o));
		repeat (100) @(negedge clk);
		if (taken) chk("asleep", 16'h0000, 16'(powered_up));
		if (taken) chk("acq", 16'h0001, 16'(acquiring));
	endtask : conv
	task pop(input logic [15:0] exp);
		int n;
		for (n = 0; n < 200 && !res_valid; n++) @(negedge clk);
		chk("valid", 16'h0001, 16'(res_valid));
		chk("result", exp, res_data);
		res_ready = 1'b1;
		@(negedge clk);
		res_ready = 1'b0;
		// let an edge pass so a following pop does not raise ready in this step
		@(negedge clk);
	endtask : pop
	////////////////////////////////////////////////////////////////////////////////
	task t_codes;
		logic [15:0] c [4];
		c = '{16'h0000, 16'hffff, 16'ha5c3, 16'h8001};
		foreach (c[i]) begin
			words = (i == 3) ? 5'h00 : 5'h01;
			conv(c[i], 1'b1);
			pop(c[i]);
		end
	endtask : t_codes
	// fifo full must hold the host off; no conversion may be lost or reordered
	task t_fifo;
		for (int i = 0; i < 4; i++) conv(16'h1111 * 16'(i + 1), 1'b1);
		conv(16'h7777, 1'b0);
		for (int i = 0; i < 4; i++) pop(16'h1111 * 16'(i + 1));
		chk("empty", 16'h0000, 16'(res_valid));
	endtask : t_fifo
	task t_chain;
		chain_sel = 1'b1;
		words = 5'h02;
		repeat (8) @(negedge clk);
		chk("chain oe", 16'h0000, 16'(lk.sdo_oe_n));
		conv(16'h3c5a, 1'b1);
		pop(16'h3c5a);
		// the ones fed on the chain input must follow the device's own word
		pop(16'hffff);
		chain_sel = 1'b0;
	endtask : t_chain
	task t_supply;
		supply_ok = 1'b0;
		repeat (5) @(negedge clk);
		chk("ready low", 16'h0000, 16'(ready));
		supply_ok = 1'b1;
		repeat (40) @(negedge clk);
		chk("ready back", 16'h0001, 16'(ready));
		conv(16'h0f0f, 1'b1);
		pop(16'h0f0f);
	endtask : t_supply
	initial begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		repeat (30) @(negedge clk);
		chk("ready", 16'h0001, 16'(ready));
		chk("hiz idle", 16'h0001, 16'(lk.sdo_oe_n));
		t_codes();
		t_fifo();
		// supply drop clears the shifter; run it while the shifter already holds zeros
		t_supply();
		t_chain();
		close_out();
	end
	initial begin
		#120000;
		n_errors++;
		close_out();
	end
endmodule : sarcv_bench
`default_nettype wire
